// ==== src/dss_pkg.sv ====
// package: register map, field layout and carriers of the drum sequencer
package dss_pkg;
	localparam int NSTEP = 16;
	localparam int NOUT = 16;
	localparam int DW = 16;
	localparam int AW = 8;
	localparam int SW = 4;
	localparam int EW = 4;
	localparam int NEVT = 16;
	localparam int SYNC_W = 4 + NEVT;
	//////////////////////////////////////////////////////////////////////
	// register map, byte addresses
	localparam logic [AW-1:0] ADDR_COUNT = 8'h00;
	localparam logic [AW-1:0] ADDR_TIMER = 8'h04;
	localparam logic [AW-1:0] ADDR_PRESET = 8'h08;
	localparam logic [AW-1:0] ADDR_CUR = 8'h0c;
	localparam logic [AW-1:0] ADDR_CTRL = 8'h10;
	localparam logic [AW-1:0] ADDR_STATUS = 8'h14;
	localparam logic [AW-1:0] ADDR_TBASE = 8'h18;
	localparam logic [1:0] REGION_MISC = 2'h0;
	localparam logic [1:0] REGION_CPS = 2'h1;
	localparam logic [1:0] REGION_PAT = 2'h2;
	localparam logic [1:0] REGION_EVT = 2'h3;
	localparam int REGION_HI = 7;
	localparam int REGION_LO = 6;
	localparam int INDEX_HI = 5;
	localparam int INDEX_LO = 2;
	localparam int ALIGN_HI = 1;
	localparam logic [1:0] ALIGNED = 2'h0;
	localparam int CTRL_EVENT_BIT = 0;
	localparam int STATUS_DONE_BIT = 0;
	//////////////////////////////////////////////////////////////////////
	// reset values and step codes
	localparam logic [DW-1:0] PRESET_RST = 16'h0001;
	localparam logic [DW-1:0] TBASE_RST = 16'h0064;
	localparam logic [DW-1:0] CTRL_RST = 16'h0000;
	localparam logic [SW-1:0] LAST_STEP = 4'hf;
	localparam logic [SW-1:0] STEP_ONE = 4'h1;
	localparam logic [EW-1:0] NO_EVENT = 4'h0;
	//////////////////////////////////////////////////////////////////////
	// timing
	localparam int unsigned CLK_PERIOD_NS = 10;
	localparam int unsigned MS_IN_NS = 1000000;
	localparam int unsigned CYC_PER_MS_DOC = MS_IN_NS / CLK_PERIOD_NS;
	//////////////////////////////////////////////////////////////////////
	// carriers and states
	typedef struct packed {
		logic [AW-1:0] addr;
		logic [DW-1:0] wdata;
		logic wr;
		logic rd;
	} dss_bus_t;
	typedef struct packed {
		logic run;
		logic rst_in;
		logic jog;
		logic start;
	} dss_ctl_t;
	typedef enum logic [1:0] {
		ST_PROG = 2'b00,
		ST_STEP = 2'b01,
		ST_DONE = 2'b10
	} dss_state_t;
endpackage

// ==== src/dss_sync.sv ====
// three-stage input synchroniser with agreement filter
`timescale 1ns/10ps
module dss_sync #(
	parameter int W = 1
) (
	// clock and reset
	input wire logic clk,
	input wire logic rst,
	// raw and filtered levels
	input wire logic [W-1:0] d,
	output logic [W-1:0] q
);
	logic [W-1:0] s1_q;
	logic [W-1:0] s2_q;
	logic [W-1:0] s3_q;
	logic [W-1:0] agree;

	// s1 feeds s2 only; a change counts once s2 and s3 agree
	assign agree = ~(s2_q ^ s3_q);

	always_ff @(posedge clk) begin
		if (rst) begin
			s1_q <= '0;
			s2_q <= '0;
			s3_q <= '0;
			q <= '0;
		end else begin
			s1_q <= d;
			s2_q <= s1_q;
			s3_q <= s2_q;
			q <= (agree & s3_q) | (~agree & q);
		end
	end
endmodule // dss_sync

// ==== src/dss_top.sv ====
// sixteen-step drum sequencer with timed and event variants
`timescale 1ns/10ps
module dss_top #(
	parameter int unsigned CYC_PER_MS = dss_pkg::CYC_PER_MS_DOC
) (
	// clock and reset
	input wire logic CORE_CLK,
	input wire logic RST,
	// register port
	input dss_pkg::dss_bus_t BUS,
	output logic [dss_pkg::DW-1:0] RDATA,
	// controlling program inputs and events
	input dss_pkg::dss_ctl_t CTL,
	input wire logic [dss_pkg::NEVT-1:0] EVENTS,
	// drum outputs
	output logic [dss_pkg::NOUT-1:0] OUTPUTS,
	output logic DONE
);
	import dss_pkg::*;

	localparam int PRE_W = $clog2(CYC_PER_MS);
	localparam logic [PRE_W-1:0] PRE_LAST = PRE_W'(CYC_PER_MS - 1);

	//////////////////////////////////////////////////////////////////////
	// synchronised inputs
	logic [SYNC_W-1:0] sync_q;
	dss_ctl_t ctl_s;
	logic [NEVT-1:0] ev_s;

	dss_sync #(.W(SYNC_W)) u_sync (
		.clk(CORE_CLK),
		.rst(RST),
		.d({CTL, EVENTS}),
		.q(sync_q)
	);
	assign {ctl_s, ev_s} = sync_q;

	//////////////////////////////////////////////////////////////////////
	// state
	dss_state_t state_q, state_d;
	logic [SW-1:0] cur_q, cur_d;
	logic [DW-1:0] cnt_q, cnt_d;
	logic [DW-1:0] tb_q, tb_d;
	logic [PRE_W-1:0] pre_q, pre_d;
	logic jog_prev_q;
	logic [DW-1:0] preset_q;
	logic [DW-1:0] ctrl_q;
	logic [DW-1:0] tbase_q;
	logic [DW-1:0] cps_q [NSTEP];
	logic [NOUT-1:0] pat_q [NSTEP];
	logic [EW-1:0] evt_q [NSTEP];
	logic [NOUT-1:0] out_d;
	logic [DW-1:0] rd_d;

	//////////////////////////////////////////////////////////////////////
	// register decode
	logic [1:0] region;
	logic [SW-1:0] idx;
	logic aligned;
	logic misc_sel;
	logic preset_wr, ctrl_wr, tbase_wr;
	logic cps_wr, pat_wr, evt_wr;
	logic [DW-1:0] misc_rd;

	assign region = BUS.addr[REGION_HI:REGION_LO];
	assign idx = BUS.addr[INDEX_HI:INDEX_LO];
	assign aligned = (BUS.addr[ALIGN_HI:0] == ALIGNED);
	assign misc_sel = aligned & (region == REGION_MISC);
	// only the preset counter takes writes among the four
	assign preset_wr = BUS.wr & (BUS.addr == ADDR_PRESET);
	assign ctrl_wr = BUS.wr & (BUS.addr == ADDR_CTRL);
	assign tbase_wr = BUS.wr & (BUS.addr == ADDR_TBASE);
	assign cps_wr = BUS.wr & aligned & (region == REGION_CPS);
	assign pat_wr = BUS.wr & aligned & (region == REGION_PAT);
	assign evt_wr = BUS.wr & aligned & (region == REGION_EVT);

	//////////////////////////////////////////////////////////////////////
	// step conditions
	logic evt_mode;
	logic [SW-1:0] preset_idx;
	logic [EW-1:0] evt_sel;
	logic evt_true;
	logic stepping, running, gate;
	logic ms_tick, cnt_tick;
	logic [DW-1:0] cnt_next;
	logic [DW-1:0] cps_cur;
	logic unused_cur;
	logic adv_tmr, jog_rise, jog_adv;
	logic step_chg;
	logic [NSTEP-1:0] used, above;
	logic [SW-1:0] nxt_idx;
	logic nxt_ok;

	assign evt_mode = ctrl_q[CTRL_EVENT_BIT];
	// preset 1..16 maps to index 0..15; 16 wraps through zero
	assign preset_idx = preset_q[SW-1:0] - STEP_ONE;
	assign evt_sel = evt_q[cur_q];
	assign evt_true = (evt_sel == NO_EVENT) | ev_s[evt_sel];
	assign stepping = (state_q == ST_STEP) & ctl_s.run & ~ctl_s.rst_in;
	assign running = stepping & ctl_s.start;
	assign gate = running & (~evt_mode | evt_true);
	assign ms_tick = gate & (pre_q == PRE_LAST);
	// timebase of zero or one ticks every millisecond
	assign cnt_tick = ms_tick & ((tb_q + DW'(1)) >= tbase_q);
	assign cnt_next = cnt_q + DW'(1);
	assign cps_cur = cps_q[cur_q];
	assign unused_cur = (cps_cur == '0);
	assign adv_tmr = running
		& (unused_cur | (cnt_tick & (cnt_next == cps_cur)));
	assign jog_rise = ctl_s.jog & ~jog_prev_q;
	assign jog_adv = stepping & evt_mode & jog_rise;

	genvar gi;
	generate
		for (gi = 0; gi < NSTEP; gi++) begin : g_used
			assign used[gi] = (cps_q[gi] != '0);
			assign above[gi] = used[gi] & (SW'(gi) > cur_q);
		end
	endgenerate

	// lowest used step above the current one
	always_comb begin
		nxt_idx = cur_q;
		nxt_ok = 1'b0;
		for (int i = NSTEP - 1; i >= 0; i--) begin
			if (above[i]) begin
				nxt_idx = SW'(i);
				nxt_ok = 1'b1;
			end
		end
	end

	//////////////////////////////////////////////////////////////////////
	// step sequencing
	always_comb begin
		state_d = state_q;
		cur_d = cur_q;
		step_chg = 1'b0;
		case (state_q)
			ST_PROG: begin
				if (ctl_s.run) begin
					state_d = ST_STEP;
					cur_d = preset_idx;
					step_chg = 1'b1;
				end
			end
			ST_STEP: begin
				if (!ctl_s.run) begin
					state_d = ST_PROG;
				end else if (ctl_s.rst_in) begin
					cur_d = preset_idx;
					step_chg = 1'b1;
				end else if (jog_adv) begin
					step_chg = 1'b1;
					if (cur_q == LAST_STEP) begin
						state_d = ST_DONE;
					end else begin
						cur_d = cur_q + STEP_ONE;
					end
				end else if (adv_tmr) begin
					step_chg = 1'b1;
					if (nxt_ok) begin
						cur_d = nxt_idx;
					end else begin
						state_d = ST_DONE;
					end
				end
			end
			ST_DONE: begin
				if (!ctl_s.run) begin
					state_d = ST_PROG;
				end else if (ctl_s.rst_in) begin
					state_d = ST_STEP;
					cur_d = preset_idx;
					step_chg = 1'b1;
				end
			end
			default: begin
				state_d = ST_PROG;
			end
		endcase
	end

	// counts and timebase prescaler; cleared on a step change, otherwise frozen unless the gate is open
	always_comb begin
		pre_d = pre_q;
		tb_d = tb_q;
		cnt_d = cnt_q;
		if (step_chg) begin
			pre_d = '0;
			tb_d = '0;
			cnt_d = '0;
		end else if (gate) begin
			pre_d = ms_tick ? '0 : pre_q + PRE_W'(1);
			if (cnt_tick) begin
				tb_d = '0;
				cnt_d = cnt_next;
			end else if (ms_tick) begin
				tb_d = tb_q + DW'(1);
			end
		end
	end

	// outputs follow the step that is about to be current
	assign out_d = (state_d == ST_PROG) ? '0 : pat_q[cur_d];

	always_ff @(posedge CORE_CLK) begin
		if (RST) begin
			state_q <= ST_PROG;
			cur_q <= '0;
			cnt_q <= '0;
			tb_q <= '0;
			pre_q <= '0;
			jog_prev_q <= 1'b0;
			OUTPUTS <= '0;
		end else begin
			state_q <= state_d;
			cur_q <= cur_d;
			cnt_q <= cnt_d;
			tb_q <= tb_d;
			pre_q <= pre_d;
			jog_prev_q <= ctl_s.jog;
			OUTPUTS <= out_d;
		end
	end

	assign DONE = (state_q == ST_DONE);

	//////////////////////////////////////////////////////////////////////
	// writable registers
	always_ff @(posedge CORE_CLK) begin
		if (RST) begin
			preset_q <= PRESET_RST;
			ctrl_q <= CTRL_RST;
			tbase_q <= TBASE_RST;
		end else begin
			if (preset_wr) preset_q <= BUS.wdata;
			if (ctrl_wr) ctrl_q <= BUS.wdata;
			if (tbase_wr) tbase_q <= BUS.wdata;
		end
	end

	generate
		for (gi = 0; gi < NSTEP; gi++) begin : g_tab
			always_ff @(posedge CORE_CLK) begin
				if (RST) begin
					cps_q[gi] <= '0;
					pat_q[gi] <= '0;
					evt_q[gi] <= NO_EVENT;
				end else if (idx == SW'(gi)) begin
					if (cps_wr) cps_q[gi] <= BUS.wdata;
					if (pat_wr) pat_q[gi] <= BUS.wdata[NOUT-1:0];
					if (evt_wr) evt_q[gi] <= BUS.wdata[EW-1:0];
				end
			end
		end
	endgenerate

	//////////////////////////////////////////////////////////////////////
	// read port; unmapped addresses read zero
	assign misc_rd =
		(BUS.addr == ADDR_COUNT) ? cnt_q :
		(BUS.addr == ADDR_TIMER) ? tb_q :
		(BUS.addr == ADDR_PRESET) ? preset_q :
		(BUS.addr == ADDR_CUR) ? DW'(cur_q) + DW'(1) :
		(BUS.addr == ADDR_CTRL) ? ctrl_q :
		(BUS.addr == ADDR_STATUS) ? DW'(DONE) << STATUS_DONE_BIT :
		(BUS.addr == ADDR_TBASE) ? tbase_q : '0;
	assign rd_d =
		!aligned ? '0 :
		(region == REGION_CPS) ? cps_q[idx] :
		(region == REGION_PAT) ? DW'(pat_q[idx]) :
		(region == REGION_EVT) ? DW'(evt_q[idx]) :
		misc_sel ? misc_rd : '0;

	always_ff @(posedge CORE_CLK) begin
		if (RST) RDATA <= '0;
		else RDATA <= BUS.rd ? rd_d : '0;
	end

	//////////////////////////////////////////////////////////////////////
	// checks
	default clocking cb @(posedge CORE_CLK); endclocking
	default disable iff (RST);

	sequence s_jog_last;
		jog_adv && (cur_q == LAST_STEP);
	endsequence
	sequence s_rst_in_done;
		(state_q == ST_DONE) ##1 (ctl_s.rst_in && ctl_s.run);
	endsequence
	sequence s_rst_held;
		(ctl_s.rst_in && ctl_s.run) [*2];
	endsequence

	AST_OUT_PATTERN: assert property (
		(ctl_s.run && state_q != ST_PROG && !pat_wr)
		|=> OUTPUTS == pat_q[cur_q])
		else $error("outputs differ from current step pattern");
	AST_TIMED_ONLY: assert property (
		(!evt_mode && stepping && !adv_tmr) |=> $stable(cur_q))
		else $error("timed step changed without elapsed counts");
	AST_ZERO_SKIP: assert property (
		(running && unused_cur && !jog_adv)
		|=> (cur_q != $past(cur_q)) || (state_q == ST_DONE))
		else $error("unused step was not skipped");
	AST_FREEZE: assert property (
		(stepping && !ctl_s.start && !jog_adv)
		|=> $stable(cur_q) && $stable(cnt_q) && $stable(tb_q))
		else $error("sequencer moved while start was low");
	AST_RUN_ENTRY: assert property (
		(state_q == ST_PROG && ctl_s.run && !pat_wr && !preset_wr)
		|=> cur_q == $past(preset_idx) && OUTPUTS == pat_q[cur_q])
		else $error("run entry did not load preset step");
	AST_EVT_GATE: assert property (
		(running && evt_mode && !evt_true && !jog_adv && !unused_cur)
		|=> $stable(cnt_q) && $stable(pre_q))
		else $error("timer ran without its event");
	AST_MATCH_ADV: assert property (
		(cnt_tick && cnt_next == cps_cur && !jog_adv)
		|=> ((cur_q != $past(cur_q)) || state_q == ST_DONE)
		&& cnt_q == '0)
		else $error("no advance on count match");
	AST_JOG_STEP: assert property (
		(jog_adv && cur_q != LAST_STEP)
		|=> cur_q == $past(cur_q) + STEP_ONE && cnt_q == '0)
		else $error("jog did not advance one step");
	AST_JOG_LAST: assert property (
		s_jog_last |=> state_q == ST_DONE && cur_q == LAST_STEP)
		else $error("jog at last step did not complete");
	AST_RST_DONE: assert property (
		s_rst_in_done |=> state_q == ST_STEP
		&& cur_q == $past(preset_idx))
		else $error("reset did not leave completion");
	AST_RST_HOLD: assert property (
		s_rst_held |-> cur_q == $past(preset_idx)
		&& cnt_q == '0 && state_q == ST_STEP)
		else $error("step ran while reset was held");
	AST_CUR_READ: assert property (
		(BUS.rd && BUS.addr == ADDR_CUR)
		|=> RDATA == DW'($past(cur_q)) + DW'(1))
		else $error("current step read back wrong");
	AST_CLR_ON_CHG: assert property (
		step_chg |=> cnt_q == '0 && tb_q == '0 && pre_q == '0)
		else $error("counts not cleared on step change");
endmodule // dss_top

// ==== test/dss_prog_model.sv ====
// model of the controlling program that feeds the drum inputs
`timescale 1ns/10ps
module dss_prog_model
	import dss_pkg::*;
(
	// clock
	input wire logic clk,
	// requests from the bench
	input wire logic run,
	input wire logic start,
	input wire logic jog,
	input wire logic man_rst,
	input wire logic auto_rst,
	input wire logic [NEVT-1:0] evt,
	// drum feedback
	input wire logic done,
	// towards the drum
	output dss_ctl_t ctl,
	output logic [NEVT-1:0] events
);
	// one scan of ladder logic per clock, so inputs move after the edge
	always @(posedge clk) begin
		ctl.run <= run;
		ctl.start <= start;
		ctl.jog <= jog;
		ctl.rst_in <= man_rst | (auto_rst & done);
		events <= evt;
	end
endmodule // dss_prog_model

// ==== test/tb_top.sv ====
// self-checking bench of the drum sequencer
`timescale 1ns/10ps
module tb_top;
	import dss_pkg::*;
	logic clk = 1'b0;
	logic rst = 1'b1;
	dss_bus_t bus = '0;
	logic [DW-1:0] rdata;
	dss_ctl_t ctl;
	logic [NEVT-1:0] events;
	logic [NEVT-1:0] evt = '0;
	logic [NOUT-1:0] outs;
	logic done;
	logic run = 1'b0, start = 1'b0, jog = 1'b0;
	logic man_rst = 1'b0, auto_rst = 1'b0;
	int n_errors = 0;
	int checks_done = 0;
	logic [DW-1:0] v;
	//////////////////////////////////////////////////////////////////////
	always #5 clk = ~clk;
	// small count period keeps each step a few cycles long
	dss_top #(.CYC_PER_MS(4)) i_dut (.CORE_CLK(clk), .RST(rst), .BUS(bus),
		.RDATA(rdata), .CTL(ctl), .EVENTS(events), .OUTPUTS(outs),
		.DONE(done));
	dss_prog_model i_prog (.clk(clk), .run(run), .start(start), .jog(jog),
		.man_rst(man_rst), .auto_rst(auto_rst), .evt(evt), .done(done),
		.ctl(ctl), .events(events));
	//////////////////////////////////////////////////////////////////////
	task automatic chk(input string name, input logic [DW-1:0] seen,
		input logic [DW-1:0] exp);
		checks_done++;
		if (seen !== exp) begin
			n_errors++;
			$display("wrong value %s expected %h seen %h", name, exp, seen);
		end
	endtask
	task automatic wr(input logic [AW-1:0] a, input logic [DW-1:0] d);
		@(posedge clk);
		bus <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
		@(posedge clk);
		bus.wr <= 1'b0;
	endtask
	task automatic rd(input logic [AW-1:0] a, output logic [DW-1:0] d);
		@(posedge clk);
		bus <= '{addr: a, wdata: 16'h0000, wr: 1'b0, rd: 1'b1};
		@(posedge clk);
		bus.rd <= 1'b0;
		#1;
		d = rdata;
	endtask
	task automatic rchk(input string name, input logic [AW-1:0] a,
		input logic [DW-1:0] exp);
		rd(a, v);
		chk(name, v, exp);
	endtask
	task automatic idle(input int n);
		repeat (n) @(posedge clk);
		#1;
	endtask
	// inputs pass a synchroniser, so each level is held a while
	task automatic pulse(input bit is_jog);
		if (is_jog) begin
			jog <= 1'b1;
		end else begin
			man_rst <= 1'b1;
		end
		idle(8);
		jog <= 1'b0;
		man_rst <= 1'b0;
		idle(8);
	endtask
	task automatic wait_done(input int n);
		for (int i = 0; i < n && done !== 1'b1; i++)
			idle(1);
	endtask
	task automatic summarize;
		$display("checks %0d mismatches %0d", checks_done, n_errors);
		if (n_errors == 0 && checks_done > 0)
			$display("NO MISMATCHES");
		else
			$display("MISMATCHES SEEN");
		$finish;
	endtask
	//////////////////////////////////////////////////////////////////////
	initial begin
		repeat (20000) @(posedge clk);
		n_errors++;
		summarize();
	end
	initial begin
		repeat (5) @(posedge clk);
		rst <= 1'b0;
		rchk("preset", ADDR_PRESET, 16'h0001);
		rchk("tbase", ADDR_TBASE, 16'h0064);
		rchk("ctrl", ADDR_CTRL, 16'h0000);
		rchk("cps16", 8'h7c, 16'h0000);
		rchk("unmapped", 8'h1c, 16'h0000);
		wr(ADDR_TBASE, 16'h0001);
		wr(8'h40, 16'h0002);
		wr(8'h44, 16'h0001);
		wr(8'h80, 16'ha5a5);
		wr(8'h84, 16'h5a5a);
		wr(ADDR_CUR, 16'h0007);
		// run without start: preset pattern, frozen step
		run <= 1'b1;
		idle(40);
		chk("outs run", outs, 16'ha5a5);
		rchk("cur frozen", ADDR_CUR, 16'h0001);
		chk("done frozen", {15'h0, done}, 16'h0000);
		start <= 1'b1;
		wait_done(100);
		chk("done", {15'h0, done}, 16'h0001);
		chk("outs step2", outs, 16'h5a5a);
		rchk("cur end", ADDR_CUR, 16'h0002);
		rchk("status", ADDR_STATUS, 16'h0001);
		// reset while start stays high holds the preset step
		man_rst <= 1'b1;
		idle(8);
		wr(ADDR_PRESET, 16'h0002);
		idle(30);
		chk("done rst", {15'h0, done}, 16'h0000);
		rchk("cur rst", ADDR_CUR, 16'h0002);
		rchk("count rst", ADDR_COUNT, 16'h0000);
		rchk("timer rst", ADDR_TIMER, 16'h0000);
		// event variant: step 1 waits on event line 3
		wr(ADDR_PRESET, 16'h0001);
		wr(ADDR_CTRL, 16'h0001);
		wr(8'hc0, 16'h0003);
		idle(8);
		man_rst <= 1'b0;
		idle(60);
		rchk("cur evt", ADDR_CUR, 16'h0001);
		evt[3] <= 1'b1;
		wait_done(100);
		chk("done evt", {15'h0, done}, 16'h0001);
		// jog from step 15 through the last step
		start <= 1'b0;
		wr(ADDR_PRESET, 16'h000f);
		pulse(1'b0);
		pulse(1'b1);
		rchk("cur jog", ADDR_CUR, 16'h0010);
		chk("done jog", {15'h0, done}, 16'h0000);
		pulse(1'b1);
		chk("done 16", {15'h0, done}, 16'h0001);
		rchk("cur 16", ADDR_CUR, 16'h0010);
		// completion fed back into reset restarts the drum
		auto_rst <= 1'b1;
		idle(20);
		auto_rst <= 1'b0;
		idle(8);
		chk("auto done", {15'h0, done}, 16'h0000);
		rchk("auto cur", ADDR_CUR, 16'h000f);
		// unused step 15 is skipped into step 16 once start returns
		wr(8'h7c, 16'h0001);
		wr(8'hbc, 16'h00ff);
		start <= 1'b1;
		wait_done(100);
		chk("skip done", {15'h0, done}, 16'h0001);
		chk("outs 16", outs, 16'h00ff);
		rchk("skip cur", ADDR_CUR, 16'h0010);
		summarize();
	end
endmodule // tb_top
